// ==== logic/sub_swap_table_read_exec.sv ====
// Execution unit: subtract, nibble exchange and program-ROM table reads
//
// Overview of operation
// RL1 - Subtract: file minus accumulator, one cycle, flags
// RL2 - Subtract result to accumulator or file by d
// RL3 - File operand: seven-bit address plus target bit
// RL4 - Exchange swaps operand nibbles, flags untouched
// RL5 - Exchange result to accumulator or file by d
// RL6 - Upper table read: ROM high byte, two cycles
// RL7 - Pointer is upper register over index byte
// RL8 - Lower table read: ROM low byte, two cycles
// RL9 - Carry set on no borrow, zero on zero
// RL10 - Upper read: bits 13..8, top two zero
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"

module sub_swap_table_read_exec
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Instruction issue from decode
    input  wire logic                   issue_valid,
    input  wire logic [`INSTR_W-1:0]    instr_word,
    input  wire logic                   table_read_lower,
    input  wire logic                   table_read_upper,
    output logic                        busy,
    output logic                        done,
    // Operands from register file
    input  wire logic [`DATA_W-1:0]     file_operand,
    input  wire logic [`DATA_W-1:0]     acc_value,
    input  wire logic [`DATA_W-1:0]     table_pointer_upper,
    input  wire logic [`DATA_W-1:0]     indirect_index_low,
    // Program ROM read port, data in the same cycle as the request
    output logic                        rom_rd,
    output logic [`ROM_ADDR_W-1:0]      rom_table_pointer,
    input  wire logic [`ROM_W-1:0]      rom_data,
    // Results
    output acc_wr_type                  acc_wr,
    output file_wr_type                 file_wr,
    output logic                        flags_we,
    output flags_type                   flags
);

    // Registered state and its next values
    exec_state_type          state_q, state_d;
    logic                    busy_q, busy_d;
    logic                    done_q, done_d;
    logic                    rom_rd_q, rom_rd_d;
    logic [`ROM_ADDR_W-1:0]  ptr_q, ptr_d;
    logic                    hi_sel_q, hi_sel_d;
    acc_wr_type              acc_q, acc_d;
    file_wr_type             file_q, file_d;
    logic                    flags_we_q, flags_we_d;
    flags_type               flags_q, flags_d;

    // Decode and datapath nets
    logic [5:0]              opc;
    logic                    dest;
    logic [`FADR_W-1:0]      fadr;
    logic                    is_sub;
    logic                    is_swap;
    logic [`DATA_W-1:0]      difference;
    logic [`DATA_W-1:0]      exchanged;
    flags_type               sub_flags;
    logic [`DATA_W-1:0]      byte_sel;
    logic                    take;
    logic                    take_table;
    logic                    take_sub;
    logic                    take_swap;

    // Field split of the instruction word
    assign opc  = instr_word[`OPC_MSB:`OPC_LSB];
    assign dest = instr_word[`DEST_BIT];                            // RL3
    assign fadr = instr_word[`FADR_MSB:0];                          // RL3
    assign is_sub  = (opc == `OPC_SUB);
    assign is_swap = (opc == `OPC_SWAP);

    sub_swap_unit u_alu (
        .minuend    (file_operand),
        .subtrahend (acc_value),
        .difference (difference),
        .sub_flags  (sub_flags),
        .exchanged  (exchanged)
    );

    // High byte is only six ROM bits wide
    assign byte_sel = hi_sel_q
        ? {{`HI_PAD_W{1'b0}}, rom_data[`ROM_HI_MSB:`ROM_HI_LSB]}    // RL10
        : rom_data[`ROM_LO_MSB:0];                                  // RL8

    // Issue while busy is ignored; decode must hold off
    assign take       = issue_valid && !busy_q;
    // Decoder flags outrank the opcode, whatever it holds
    assign take_table = take && (table_read_lower || table_read_upper);
    assign take_sub   = take && !take_table && is_sub;
    assign take_swap  = take && !take_table && is_swap;

    // Sequencing: state, busy, ROM request and pointer
    always_comb begin
        state_d  = state_q;
        busy_d   = busy_q;
        done_d   = 1'b0;
        rom_rd_d = 1'b0;
        ptr_d    = ptr_q;
        hi_sel_d = hi_sel_q;
        case (state_q)
            ST_IDLE: begin
                if (take_table) begin
                    // Upper register over index byte
                    ptr_d    = {table_pointer_upper[`PTR_UPPER_W-1:0],
                                indirect_index_low};                // RL7
                    hi_sel_d = table_read_upper;                    // RL6
                    rom_rd_d = 1'b1;
                    busy_d   = 1'b1;
                    state_d  = ST_TBL_WAIT;
                end else if (take_sub || take_swap) begin
                    // Single-cycle ops finish at the next edge
                    done_d = 1'b1;                                  // RL1
                end
            end
            ST_TBL_WAIT: begin
                // Second cycle closes the table read
                done_d  = 1'b1;                                     // RL6
                busy_d  = 1'b0;
                state_d = ST_IDLE;
            end
            default: begin
                // Unused encoding falls back to idle
                state_d = ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // Write-back: result strobes, data and flags
    always_comb begin
        acc_d       = '0;
        acc_d.data  = acc_q.data;
        file_d      = '0;
        file_d.addr = file_q.addr;
        file_d.data = file_q.data;
        flags_we_d  = 1'b0;
        flags_d     = flags_q;
        if (state_q == ST_TBL_WAIT) begin
            // ROM word present in this cycle; flags left alone
            acc_d.we   = 1'b1;                                      // RL6
            acc_d.data = byte_sel;                                  // RL8
        end else if (take_sub) begin
            flags_we_d = 1'b1;                                      // RL1
            flags_d    = sub_flags;                                 // RL9
            if (dest == `DEST_ACC) begin
                acc_d.we   = 1'b1;                                  // RL2
                acc_d.data = difference;
            end else begin
                file_d.we   = 1'b1;                                 // RL2
                file_d.addr = fadr;
                file_d.data = difference;
            end
        end else if (take_swap) begin                               // RL4
            // Exchange never raises the flags strobe
            if (dest == `DEST_ACC) begin
                acc_d.we   = 1'b1;                                  // RL5
                acc_d.data = exchanged;
            end else begin
                file_d.we   = 1'b1;                                 // RL5
                file_d.addr = fadr;
                file_d.data = exchanged;
            end
        end
    end

    // Synchronous reset only; every register clocks each edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            rom_rd_q <= 1'b0;
            ptr_q    <= '0;
            hi_sel_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            busy_q   <= busy_d;
            done_q   <= done_d;
            rom_rd_q <= rom_rd_d;
            ptr_q    <= ptr_d;
            hi_sel_q <= hi_sel_d;
        end
    end

    // Data fields hold; strobes drop after one cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q      <= '0;
            file_q     <= '0;
            flags_we_q <= 1'b0;
            flags_q    <= '0;
        end else begin
            acc_q      <= acc_d;
            file_q     <= file_d;
            flags_we_q <= flags_we_d;
            flags_q    <= flags_d;
        end
    end

    // Every output straight from a register
    assign busy              = busy_q;
    assign done              = done_q;
    assign rom_rd            = rom_rd_q;
    assign rom_table_pointer = ptr_q;
    assign acc_wr            = acc_q;
    assign file_wr           = file_q;
    assign flags_we          = flags_we_q;
    assign flags             = flags_q;

endmodule

`default_nettype wire

// ==== logic/exec_params.svh ====
// Constants for the subtract, nibble-exchange and table-read execution unit
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

`define INSTR_W        14
`define FADR_W         7
`define DATA_W         8
`define ROM_W          14
`define ROM_ADDR_W     12
`define PTR_UPPER_W    4

`define OPC_MSB        13
`define OPC_LSB        8
`define DEST_BIT       7
`define FADR_MSB       6
`define OPC_SUB        6'h02
`define OPC_SWAP       6'h0e
`define DEST_ACC       1'b0

`define ROM_HI_MSB     13
`define ROM_HI_LSB     8
`define ROM_LO_MSB     7
`define HI_PAD_W       2

`define SUB_CYCLES     1
`define TABLE_CYCLES   2

`endif

// ==== logic/exec_pkg.sv ====
// Types shared by the execution unit and its arithmetic helper
`include "exec_params.svh"

package exec_pkg;

    typedef enum logic [0:0] {
        ST_IDLE     = 1'b0,
        ST_TBL_WAIT = 1'b1
    } exec_state_type;

    typedef struct packed {
        logic                 carry;
        logic                 half_carry_flag;
        logic                 zero;
    } flags_type;

    typedef struct packed {
        logic                 we;
        logic [`FADR_W-1:0]   addr;
        logic [`DATA_W-1:0]   data;
    } file_wr_type;

    typedef struct packed {
        logic                 we;
        logic [`DATA_W-1:0]   data;
    } acc_wr_type;

endpackage

// ==== logic/sub_swap_unit.sv ====
// Combinational subtract and nibble-exchange datapath
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"

module sub_swap_unit
    import exec_pkg::*;
(
    // Operands
    input  wire logic [`DATA_W-1:0] minuend,
    input  wire logic [`DATA_W-1:0] subtrahend,
    // Results
    output logic      [`DATA_W-1:0] difference,
    output flags_type               sub_flags,
    output logic      [`DATA_W-1:0] exchanged
);

    logic [`DATA_W:0] full_sum;
    logic [4:0]       nib_sum;

    // Two's complement: f + ~w + 1, carry out means no borrow
    always_comb begin
        full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001; // RL1
        nib_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                   + 5'h01;
        difference                = full_sum[`DATA_W-1:0];
        sub_flags.carry           = full_sum[`DATA_W];              // RL9
        sub_flags.half_carry_flag = nib_sum[4];                     // RL1
        sub_flags.zero            = (full_sum[`DATA_W-1:0] == 8'h00); // RL9
        exchanged = {minuend[3:0], minuend[7:4]};                   // RL4
    end

endmodule

`default_nettype wire

// ==== verif/exec_sva.sv ====
// Port assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"
module exec_sva
    import exec_pkg::*;
(
    // Control
    input wire logic        clk_sys, rst_n, issue_valid, busy, done,
    input wire logic        table_read_lower, table_read_upper,
    input wire logic        rom_rd, flags_we,
    // Data
    input wire logic [13:0] instr_word, rom_data,
    input wire logic [7:0]  file_operand, acc_value,
    input wire logic [7:0]  table_pointer_upper, indirect_index_low,
    input wire logic [11:0] rom_table_pointer,
    input wire acc_wr_type  acc_wr,
    input wire file_wr_type file_wr,
    input wire flags_type   flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire       tk   = issue_valid & !busy;
    wire       tbl  = table_read_lower | table_read_upper;
    wire       sub  = tk & !tbl & instr_word[13:8] == `OPC_SUB;
    wire       swp  = tk & !tbl & instr_word[13:8] == `OPC_SWAP;
    wire [7:0] diff = file_operand - acc_value;
    sequence tbl_seq;
        rom_rd && busy && !flags_we ##1 acc_wr.we && done && !busy;
    endsequence
    a_sub_to_acc: assert property (sub && !instr_word[7] |=>
        acc_wr.we && !file_wr.we && done && acc_wr.data == $past(diff))
        else $error("subtract to accumulator wrong");
    a_sub_to_file: assert property (sub && instr_word[7] |=>
        file_wr.we && !acc_wr.we && file_wr.data == $past(diff)
        && file_wr.addr == $past(instr_word[6:0]))
        else $error("subtract to file wrong");
    a_sub_flags: assert property (sub |=> flags_we && flags ==
        $past({file_operand >= acc_value,
        file_operand[3:0] >= acc_value[3:0], diff == 8'h00}))
        else $error("subtract flags wrong");
    a_swap_data: assert property (swp |=>
        acc_wr.we == !$past(instr_word[7]) && acc_wr.we != file_wr.we
        && (acc_wr.we ? acc_wr.data : file_wr.data)
        == {$past(file_operand[3:0]), $past(file_operand[7:4])})
        else $error("exchange result wrong");
    a_swap_flags: assert property (swp |=> !flags_we && $stable(flags))
        else $error("exchange touched flags");
    a_tbl_timing: assert property (tk && tbl |=> tbl_seq)
        else $error("table read timing wrong");
    a_tbl_flags: assert property (tk && tbl |=> ##1 !flags_we
        && $stable(flags))
        else $error("table read touched flags");
    a_tbl_addr: assert property (tk && tbl |=> rom_table_pointer ==
        $past({table_pointer_upper[3:0], indirect_index_low}))
        else $error("table address wrong");
    a_tbl_upper: assert property (tk && table_read_upper |=> ##1
        acc_wr.data == {2'b00, $past(rom_data[13:8])})
        else $error("upper table byte wrong");
    a_tbl_lower: assert property (tk && table_read_lower
        && !table_read_upper |=> ##1 acc_wr.data == $past(rom_data[7:0]))
        else $error("lower table byte wrong");
endmodule
bind sub_swap_table_read_exec exec_sva chk_u (.clk_sys, .rst_n,
    .issue_valid, .busy, .done, .table_read_lower, .table_read_upper,
    .rom_rd, .flags_we, .instr_word, .rom_data, .file_operand,
    .acc_value, .table_pointer_upper, .indirect_index_low,
    .rom_table_pointer, .acc_wr, .file_wr, .flags);
`default_nettype wire

// ==== verif/rom_model.sv ====
// Program ROM model answering table-read requests
`timescale 1ns/1ps
`default_nettype none
module rom_model (
    // Request and word
    input  wire logic        clk_sys,
    input  wire logic        rom_rd,
    input  wire logic [11:0] rom_table_pointer,
    output var  logic [13:0] rom_data
);
    initial rom_data = 14'h2a55;
    // Word flips outside a read so a late sample cannot pass
    always @(posedge clk_sys) begin
        #1 rom_data = rom_rd ? 14'h3789 ^ {2'h0, rom_table_pointer}
                             : ~rom_data;
    end
endmodule
`default_nettype wire

// ==== verif/sub_swap_table_read_exec_tb.sv ====
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"
module sub_swap_table_read_exec_tb import exec_pkg::*;;
    logic        clk_sys, rst_n, issue_valid, busy, done, rom_rd;
    logic        table_read_lower, table_read_upper, flags_we;
    logic [13:0] instr_word, rom_data;
    logic [7:0]  file_operand, acc_value;
    logic [7:0]  table_pointer_upper, indirect_index_low;
    logic [11:0] rom_table_pointer;
    acc_wr_type  acc_wr;
    file_wr_type file_wr;
    flags_type   flags;
    int          mismatches = 0;
    int          checked = 0;
    sub_swap_table_read_exec dut_u (.clk_sys, .rst_n, .issue_valid,
        .instr_word, .table_read_lower, .table_read_upper, .busy, .done,
        .file_operand, .acc_value, .table_pointer_upper,
        .indirect_index_low, .rom_rd, .rom_table_pointer, .rom_data,
        .acc_wr, .file_wr, .flags_we, .flags);
    rom_model rom_u (.clk_sys, .rom_rd, .rom_table_pointer, .rom_data);
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Valid stays up so consecutive issues land back to back
    task automatic go(logic [13:0] iw, logic lo, logic up, logic [7:0] f);
        issue_valid = 1'b1;
        instr_word = iw;
        table_read_lower = lo;
        table_read_upper = up;
        file_operand = f;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic idle;
        issue_valid = 1'b0;
        table_read_lower = 1'b0;
        table_read_upper = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic t_sub;
        logic [7:0] fs [4] = '{8'h03, 8'h02, 8'h01, 8'h10};
        acc_value = 8'h02;
        for (int i = 0; i < 4; i++) begin
            go({`OPC_SUB, i[0], 7'h7f - i[6:0]}, 1'b0, 1'b0, fs[i]);
            chk("sub data", {8'h00, fs[i] - 8'h02},
                i[0] ? file_wr.data : acc_wr.data);
            chk("sub dest", {i[0], ~i[0], 1'b1},
                {file_wr.we, acc_wr.we, done});
            if (i[0])
                chk("sub addr", 7'h7f - i[6:0], file_wr.addr);
            chk("sub flags", {1'b1, fs[i] >= 8'h02, fs[i][3:0] >= 4'h2,
                fs[i] == 8'h02}, {flags_we, flags});
        end
        idle;
        $display("subtract test ended");
    endtask
    task automatic t_swap;
        for (int d = 0; d < 2; d++) begin
            go({`OPC_SWAP, d[0], 7'h00}, 1'b0, 1'b0, 8'ha5);
            chk("swap data", 8'h5a,
                d[0] ? file_wr.data : acc_wr.data);
            chk("swap dest", {d[0], ~d[0], 1'b0},
                {file_wr.we, acc_wr.we, flags_we});
        end
        chk("swap flags", 3'b100, flags);
        idle;
        $display("exchange test ended");
    endtask
    // Valid held high in the busy cycle must be ignored
    task automatic t_tbl(logic up);
        table_pointer_upper = 8'hf2;
        indirect_index_low = 8'h34;
        go(14'h0000, ~up, up, 8'h00);
        chk("table ptr", 12'h234, rom_table_pointer);
        chk("table c1", 3'b110, {rom_rd, busy, flags_we});
        go({`OPC_SUB, 1'b1, 7'h11}, 1'b0, 1'b0, 8'h77);
        chk("table c2", {3'b110, up ? 8'h35 : 8'hbd},
            {acc_wr.we, done, busy, acc_wr.data});
        chk("table refused", 2'b00, {flags_we, file_wr.we});
        idle;
        $display("table read test ended");
    endtask
    task automatic complete_run;
        $display("Counts: %0d checked, %0d mismatches", checked,
            mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        issue_valid = 1'b0;
        instr_word = 14'h0000;
        table_read_lower = 1'b0;
        table_read_upper = 1'b0;
        file_operand = 8'h00;
        acc_value = 8'h00;
        table_pointer_upper = 8'h00;
        indirect_index_low = 8'h00;
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        idle;
        t_sub;
        t_swap;
        t_tbl(1'b1);
        t_tbl(1'b0);
        complete_run;
    end
    initial begin
        #2000;
        mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
